// ==== design/pmb_master.sv ====
// Purpose: pci bus master interface, requests bus and runs dma transactions
// Assumes: bus pins synchronised by two flops; apb slave for registers
// Notes: terminations, preemption and master abort are not handled
//
// Function
// [R01] memory read for init, descriptors, nonburst tx
// [R02] memory write for descriptor and rx writes
// [R03] never issue other commands
// [R04] after grant wait frame and irdy idle
// [R05] no address stepping, stepping bit zero
// [R06] burst without extended request: drop req at frame
// [R07] burst with extended request: hold req to last
// [R08] request held until grant, stop ignored
// [R09] hardware or software reset drops req
// [R10] nonburst reads use memory read, all lanes
// [R11] several nonburst reads, req until last frame
// [R12] irdy right after address phase
// [R13] hold irdy until trdy seen
// [R14] burst reads need enable; descriptors need style three
// [R15] burst init/descriptor reads use memory read
// [R16] tx burst reads: line or multiple by select
// [R17] burst address low bits zero, all lanes
// [R18] one burst per mastership period
// [R19] frame drops when second-to-last phase completes
// [R20] writes nonburst memory write with exact lanes
// [R21] several nonburst writes, req until last frame
// [R22] writes zero wait state after address phase
// [R23] start only with grant and idle bus
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module pmb_master import pmb_pkg::*; #(
  parameter int LEN_W = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gntN,
  input wire logic frameInN,
  input wire logic irdyInN,
  input wire logic trdyInN,
  input wire logic devselInN,
  input wire logic [31:0] adIn,
  output logic reqN,
  output logic [31:0] adOut,
  output logic adOe,
  output logic [3:0] cbeOut,
  output logic frameOutN,
  output logic irdyOutN,
  output logic ctlOe
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [4:0] pinsS;
  logic [31:0] adS;
  logic gntS, frameS, irdyS, trdyS, devselS;

  pmb_sync #(.W(5), .INIT(5'h1F)) uSyncCtl (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d({gntN, frameInN, irdyInN, trdyInN, devselInN}),
    .q(pinsS)
  );
  pmb_sync #(.W(32), .INIT(32'h0000_0000)) uSyncAd (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(adIn),
    .q(adS)
  );
  assign {gntS, frameS, irdyS, trdyS, devselS} = pinsS;

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  logic [31:0] control;
  logic [31:0] dmaAddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0] kind;
  logic isWrite;
  logic [3:0] wrLanes;
  logic [LEN_W-1:0] count;
  logic [LEN_W-1:0] left;
  logic busy;
  logic done;
  logic startPulse;
  pmb_state_t state;
  logic useBurst;
  logic [3:0] cmd;
  logic softReset;
  logic wrEn;

  assign wrEn = psel && penable && pwrite;
  assign startPulse = wrEn && (paddr == OFS_START) && !busy;
  assign softReset = control[CTL_SRESET_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      control <= CONTROL_RESET;
      dmaAddr <= 32'h0000_0000;
      wdata <= 32'h0000_0000;
    end else if (wrEn) begin
      if (paddr == OFS_CONTROL) begin
        control <= pwdata;
      end else if (paddr == OFS_ADDR) begin
        dmaAddr <= pwdata;
      end else if (paddr == OFS_WDATA) begin
        wdata <= pwdata;
      end
    end else if (softReset) begin
      control[CTL_SRESET_BIT] <= 1'b0;
    end
  end

  // start word: [1:0] kind, [2] write, [7:4] lanes, [15:8] phase count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      kind <= 2'b00;
      isWrite <= 1'b0;
      wrLanes <= 4'h0;
      count <= LEN_W'(LEN_RESET);
    end else if (startPulse) begin
      kind <= pwdata[1:0];
      isWrite <= pwdata[2];
      wrLanes <= pwdata[7:4];
      count <= (pwdata[15:8] == 8'h00) ? LEN_W'(LEN_RESET) : LEN_W'(pwdata[15:8]);
    end
  end

  // apb: zero wait state, unmapped reads zero with error
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == OFS_CONTROL) begin
          prdata <= control;
        end else if (paddr == OFS_ADDR) begin
          prdata <= dmaAddr;
        end else if (paddr == OFS_WDATA) begin
          prdata <= wdata;
        end else if (paddr == OFS_START) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == OFS_STATUS) begin
          prdata <= {29'h0, done, busy, reqN};
        end else if (paddr == OFS_RDATA) begin
          prdata <= rdata;
        end else if (paddr == OFS_PCICMD) begin
          prdata <= 32'h0000_0000; // see [R05]
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // command and mode selection
  // -------------------------------------------------------------
  always_comb begin
    useBurst = 1'b0;
    if (!isWrite && control[CTL_BREAD_BIT] && count > LEN_W'(1)) begin // see [R14]
      if (kind == KIND_DESC) begin
        useBurst = (control[CTL_STYLE_LSB +: 8] == STYLE_BURST); // see [R14]
      end else begin
        useBurst = 1'b1;
      end
    end
  end

  always_comb begin
    if (isWrite) begin
      cmd = CMD_MEM_WRITE; // see [R02] see [R20]
    end else if (useBurst && kind == KIND_TXBUF) begin
      cmd = control[CTL_TX_BURST_COMMAND_SELECT_BIT] ? CMD_MEM_READ_MULT : CMD_MEM_READ_LINE; // see [R16]
    end else begin
      cmd = CMD_MEM_READ; // see [R01] see [R10] see [R15] see [R03]
    end
  end

  // -------------------------------------------------------------
  // bus state machine
  // -------------------------------------------------------------
  logic busIdle;
  logic lastPhase;
  logic [31:0] curAddr;
  assign busIdle = frameS && irdyS;
  assign lastPhase = (left == LEN_W'(1));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      reqN <= 1'b1;
      adOut <= 32'h0000_0000;
      adOe <= 1'b0;
      cbeOut <= BE_ALL;
      frameOutN <= 1'b1;
      irdyOutN <= 1'b1;
      ctlOe <= 1'b0;
      left <= '0;
      curAddr <= 32'h0000_0000;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
    end else if (softReset) begin
      state <= ST_IDLE; // see [R09]
      reqN <= 1'b1; // see [R09]
      adOe <= 1'b0;
      frameOutN <= 1'b1;
      irdyOutN <= 1'b1;
      ctlOe <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (wrEn && paddr == OFS_STATUS && pwdata[2]) begin
        done <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (startPulse) begin
            busy <= 1'b1;
            reqN <= 1'b0;
            left <= LEN_W'(pwdata[15:8] == 8'h00 ? LEN_RESET : pwdata[15:8]);
            curAddr <= {dmaAddr[31:2], 2'b00};
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          // request stays up regardless of stop or suspend bits; see [R08]
          if (!gntS && busIdle) begin // see [R04] see [R23]
            adOut <= curAddr; // see [R17]
            adOe <= 1'b1;
            cbeOut <= cmd;
            frameOutN <= 1'b0;
            ctlOe <= 1'b1;
            state <= ST_ADDR;
            if (useBurst) begin
              reqN <= control[CTL_EXTENDED_REQUEST_HOLD_BIT] ? 1'b0 : 1'b1; // see [R06]
            end else if (lastPhase) begin
              reqN <= 1'b1; // see [R11] see [R21]
            end
          end
        end
        ST_ADDR: begin
          irdyOutN <= 1'b0; // see [R12] see [R22]
          adOe <= isWrite;
          adOut <= wdata;
          cbeOut <= isWrite ? wrLanes : BE_ALL; // see [R20] see [R10] see [R17]
          if (!useBurst || lastPhase) begin
            frameOutN <= 1'b1;
            if (useBurst) begin
              reqN <= 1'b1; // see [R07]
            end
          end
          state <= ST_DATA;
        end
        ST_DATA: begin
          if (!trdyS && !devselS) begin // see [R13]
            if (!isWrite) begin
              rdata <= adS;
            end
            left <= left - LEN_W'(1);
            curAddr <= curAddr + 32'h0000_0004;
            if (lastPhase) begin
              irdyOutN <= 1'b1;
              state <= ST_TURN;
            end else if (useBurst) begin
              if (left == LEN_W'(2)) begin
                frameOutN <= 1'b1; // see [R19]
                reqN <= 1'b1; // see [R07]
              end
            end else begin
              irdyOutN <= 1'b1;
              frameOutN <= 1'b1;
              state <= ST_TURN;
            end
          end
        end
        ST_TURN: begin
          adOe <= 1'b0;
          ctlOe <= 1'b0;
          if (left == '0) begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE; // see [R18]
          end else begin
            state <= ST_REQ; // see [R11] see [R21]
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== shared/pmb_pkg.sv ====
// Purpose: constants and types for the pci master bus interface
// Assumes: apb register window, 32-bit words
// Notes: command codes are the bus's own encodings
package pmb_pkg;
  // -------------------------------------------------------------
  // bus commands
  // -------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'hE;
  localparam logic [3:0] BE_ALL = 4'h0;
  // -------------------------------------------------------------
  // register offsets (byte addresses)
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_PCICMD = 8'h18;
  // -------------------------------------------------------------
  // control field positions
  // -------------------------------------------------------------
  localparam int CTL_BREAD_BIT = 6;
  localparam int CTL_EXTENDED_REQUEST_HOLD_BIT = 8;
  localparam int CTL_TX_BURST_COMMAND_SELECT_BIT = 9;
  localparam int CTL_STYLE_LSB = 16;
  localparam int CTL_STOP_BIT = 24;
  localparam int CTL_SUSPEND_REQUEST_BIT_BIT = 25;
  localparam int CTL_SRESET_BIT = 26;
  localparam int PCICMD_STEP_BIT = 7;
  localparam logic [7:0] STYLE_BURST = 8'h03;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [7:0] LEN_RESET = 8'h01;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [1:0] {KIND_INIT, KIND_DESC, KIND_TXBUF, KIND_RXBUF} pmb_kind_t;
  typedef enum {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN} pmb_state_t;
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe;
    logic adOe;
    logic frameN;
    logic irdyN;
    logic ctlOe;
  } pmb_drive_t;
endpackage

// ==== design/pmb_sync.sv ====
// Purpose: two-stage synchroniser for bus pins
// Assumes: single clock ref_clk
// Notes: first stage read by the second only
`timescale 1ns/1ns
module pmb_sync import pmb_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== tb/pmb_master_monitor.sv ====
// Purpose: bus and register-port checks for pmb_master
// Assumes: the far side keeps grant while the request is low
// Notes: control bits are tracked from apb writes
`timescale 1ns/1ns
module pmb_master_monitor import pmb_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic gntN,
  input wire logic frameInN,
  input wire logic trdyInN,
  input wire logic reqN,
  input wire logic [31:0] adOut,
  input wire logic [3:0] cbeOut,
  input wire logic frameOutN,
  input wire logic irdyOutN,
  input wire logic ctlOe
);
  // ------------------------------------------------------------
  // helpers and checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic ext;
  wire addrPh = ctlOe && !frameOutN && irdyOutN;
  wire txBurst = addrPh && (cbeOut == CMD_MEM_READ_LINE || cbeOut == CMD_MEM_READ_MULT);
  wire ctlWr = psel && penable && pwrite && pready && paddr == OFS_CONTROL;
  wire srst = ctlWr && pwdata[CTL_SRESET_BIT];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext <= 1'b0;
    end else if (ctlWr) begin
      ext <= pwdata[CTL_EXTENDED_REQUEST_HOLD_BIT];
    end
  end
  sequence s_addr;
    addrPh;
  endsequence
  sequence s_data;
    !irdyOutN;
  endsequence
  a_cmd_legal: assert property (s_addr |-> cbeOut inside {4'h6, 4'h7, 4'hC, 4'hE})
    else $error("illegal bus command");
  a_irdy_next: assert property (s_addr |=> s_data) else $error("irdy late");
  a_irdy_hold: assert property (s_data and trdyInN && $past(trdyInN) && $past(trdyInN, 2)
    && $past(trdyInN, 3) |=> s_data) else $error("irdy dropped early");
  a_read_lanes: assert property (s_addr and cbeOut != CMD_MEM_WRITE |=> cbeOut == BE_ALL)
    else $error("read lanes off");
  a_burst_align: assert property (txBurst |-> adOut[1:0] == 2'b00) else $error("burst misaligned");
  a_req_drop: assert property (txBurst && !ext |-> reqN) else $error("req kept");
  a_req_ext: assert property (txBurst && ext |-> !reqN ##1 !frameOutN) else $error("req dropped");
  a_grant_idle: assert property ($fell(frameOutN) |-> !$past(gntN, 2) && $past(frameInN, 2))
    else $error("start on busy bus");
  // soft reset takes effect one edge after its write, so that edge is excused too
  a_req_hold: assert property (!reqN && gntN && !srst && !$past(srst) |=> !reqN)
    else $error("req withdrawn");
  a_soft_reset: assert property (srst |-> ##[1:2] reqN) else $error("req after soft reset");
  a_step_zero: assert property (psel && penable && pready && !pwrite && paddr == OFS_PCICMD
    |-> !prdata[PCICMD_STEP_BIT]) else $error("stepping bit set");
endmodule
bind pmb_master pmb_master_monitor mon (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .gntN(gntN),
  .frameInN(frameInN), .trdyInN(trdyInN), .reqN(reqN), .adOut(adOut), .cbeOut(cbeOut),
  .frameOutN(frameOutN), .irdyOutN(irdyOutN), .ctlOe(ctlOe));

// ==== tb/pmb_far_model.sv ====
// Purpose: arbiter and memory target facing pmb_master
// Assumes: one data phase per trdy pulse
// Notes: trdy spacing covers the master's input lag
`timescale 1ns/1ns
module pmb_far_model import pmb_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reqN,
  input wire logic frameOutN,
  input wire logic irdyOutN,
  input wire logic ctlOe,
  input wire logic [3:0] cbeOut,
  input wire logic holdGnt,
  input wire logic busOther,
  input wire logic [3:0] slow,
  output logic gntN,
  output logic frameInN,
  output logic irdyInN,
  output logic trdyInN,
  output logic devselInN,
  output logic [31:0] adIn,
  output logic [7:0] frames,
  output logic [15:0] phases,
  output logic [3:0] beSeen
);
  // ------------------------------------------------------------
  // bus model
  // ------------------------------------------------------------
  logic [3:0] cnt;
  logic [15:0] cyc;
  // lines are pulled up when no master drives them
  assign frameInN = ctlOe ? frameOutN : !busOther;
  assign irdyInN = ctlOe ? irdyOutN : !busOther;
  assign devselInN = trdyInN;
  // undriven data changes every cycle so stale values never match
  assign adIn = !trdyInN ? {16'h5A5A, phases} : {16'hA5A5, cyc};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gntN <= 1'b1;
    end else begin
      gntN <= reqN | holdGnt;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trdyInN <= 1'b1;
      cnt <= 4'h0;
    end else if (!trdyInN) begin
      trdyInN <= 1'b1;
      cnt <= 4'h0;
    end else if (ctlOe && !irdyInN) begin
      // the target answers only our own transfers, never another master's
      if (cnt == slow + 4'h5) begin
        trdyInN <= 1'b0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frames <= 8'h00;
      phases <= 16'h0000;
      beSeen <= 4'h0;
      cyc <= 16'h0000;
    end else begin
      cyc <= cyc + 16'h0001;
      if (ctlOe && !frameOutN && irdyOutN) begin
        frames <= frames + 8'h01;
      end
      if (!irdyInN && !trdyInN) begin
        phases <= phases + 16'h0001;
        beSeen <= cbeOut;
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
// Purpose: directed bench for pmb_master
// Assumes: apb register map as handed over
// Notes: one row of the tables per test case, ten cases over the four transfer kinds
`timescale 1ns/1ns
module tb import pmb_pkg::*; ;
  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, holdGnt = 0, busOther = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] slow = 4'h0;
  logic [31:0] prdata, adIn, adOut, addrCap;
  logic pready, pslverr, gntN, frameInN, irdyInN, trdyInN, devselInN, reqN, adOe, frameOutN, irdyOutN, ctlOe;
  logic [3:0] cbeOut, beSeen;
  logic [7:0] frames;
  logic [15:0] phases;
  int num_errors = 0, checks = 0;
  localparam logic [31:0] CTL_T [10] = '{0, 0, 0, 32'h0040, 32'h0340, 32'h0040, 32'h0003_0040, 32'h0040, 0, 32'h0040};
  localparam logic [31:0] START_T [10] = '{32'h0100, 32'h0201, 32'h0102, 32'h0302, 32'h0302, 32'h0201, 32'h0201,
    32'h0200, 32'h0235, 32'h0207};
  localparam logic [3:0] CMD_T [10] = '{4'h6, 4'h6, 4'h6, 4'hE, 4'hC, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7};
  localparam logic [7:0] FR_T [10] = '{1, 2, 1, 1, 1, 2, 1, 1, 2, 2};
  always #5 ref_clk = ~ref_clk;
  pmb_master dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gntN(gntN), .frameInN(frameInN),
    .irdyInN(irdyInN), .trdyInN(trdyInN), .devselInN(devselInN), .adIn(adIn), .reqN(reqN), .adOut(adOut),
    .adOe(adOe), .cbeOut(cbeOut), .frameOutN(frameOutN), .irdyOutN(irdyOutN), .ctlOe(ctlOe));
  pmb_far_model far (.ref_clk(ref_clk), .nrst(nrst), .reqN(reqN), .frameOutN(frameOutN), .irdyOutN(irdyOutN),
    .ctlOe(ctlOe), .cbeOut(cbeOut), .holdGnt(holdGnt), .busOther(busOther), .slow(slow), .gntN(gntN),
    .frameInN(frameInN), .irdyInN(irdyInN), .trdyInN(trdyInN), .devselInN(devselInN), .adIn(adIn),
    .frames(frames), .phases(phases), .beSeen(beSeen));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    // request held until the edge that samples pready high; only the watchdog ends a hang
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(0, a, 0, q, e);
  endtask
  task automatic run(input int i);
    logic [31:0] q;
    logic [7:0] f0;
    logic [15:0] p0;
    f0 = frames;
    p0 = phases;
    wr(OFS_CONTROL, CTL_T[i]);
    wr(OFS_ADDR, 32'h0000_1000);
    wr(OFS_WDATA, 32'hC0DE_0001);
    wr(OFS_START, START_T[i]);
    if (i == 0) begin
      repeat (30) @(negedge ref_clk);
      check("frames_busy", frames, f0);
      @(posedge ref_clk) busOther <= 0;
    end
    q = 0;
    for (int n = 0; n < 100 && q[2] !== 1'b1; n++) rd(OFS_STATUS, q);
    wr(OFS_STATUS, 32'h0000_0004);
    check("frames", frames - f0, FR_T[i]);
    check("phases", phases - p0, START_T[i][15:8]);
    check("addr", addrCap, 32'h0000_1000 + {FR_T[i] - 8'h01, 2'b00});
    check("lanes", beSeen, START_T[i][2] ? START_T[i][7:4] : BE_ALL);
    if (!START_T[i][2]) begin
      rd(OFS_RDATA, q);
      check("rdata", q, {16'h5A5A, p0 + START_T[i][15:8] - 16'h1});
    end
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  logic [3:0] cmdCap;
  always @(posedge ref_clk) begin
    if (ctlOe && !frameOutN && irdyOutN) begin
      cmdCap <= cbeOut;
      addrCap <= adOut;
    end
  end
  initial begin
    logic [31:0] q;
    logic e;
    repeat (5) @(posedge ref_clk);
    nrst <= 1;
    rd(OFS_CONTROL, q);
    check("control_reset", q, CONTROL_RESET);
    rd(OFS_STATUS, q);
    check("req_reset", q[0], 1);
    rd(OFS_PCICMD, q);
    check("step_bit", q[PCICMD_STEP_BIT], 0);
    apb(0, 8'hFC, 0, q, e);
    check("unmapped_err", e, 1);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      slow <= {2'b00, i[0], 1'b0};
      busOther <= (i == 0);
      run(i);
      check("cmd", cmdCap, CMD_T[i]);
    end
    @(posedge ref_clk) holdGnt <= 1;
    wr(OFS_START, 32'h0000_0100);
    wr(OFS_CONTROL, 32'h0300_0000);
    repeat (5) @(posedge ref_clk);
    rd(OFS_STATUS, q);
    check("req_held", q[0], 0);
    wr(OFS_CONTROL, 32'h0400_0000);
    rd(OFS_STATUS, q);
    check("soft_reset", q[1:0], 2'b01);
    final_report;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    final_report;
  end
endmodule
